// >>> logic/gtc_prescaler.sv
// Purpose: input prescaler of the timer, divides qualified ticks by 1, 2, 4 or 8
// Assumes: tick is a qualified strobe in the clk domain, high for one or many consecutive cycles
// Notes:   counter is hidden from software; only a clear reaches it
`timescale 1ns/1ns
`default_nettype none

module gtc_prescaler
  import gtc_pkg::*;
#(
  parameter int SEL_W = GTC_PS_SEL_W,
  parameter int CNT_W = GTC_PS_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             clr,
  input  wire logic             tick,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  outTick
);

  logic [CNT_W-1:0] psCnt_ff;
  logic [CNT_W-1:0] divMask;

  // mask of low bits that must all be set before a tick passes
  assign divMask = CNT_W'((1 << sel) - 1);
  assign outTick = tick && ((psCnt_ff & divMask) == divMask);

  // -------------------------------------------------------------------------
  // prescale counter
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      psCnt_ff <= '0;
    end else if (ce) begin
      if (clr) begin
        psCnt_ff <= '0;
      end else if (tick) begin
        psCnt_ff <= outTick ? '0 : psCnt_ff + CNT_W'(1);
      end
    end
  end

endmodule : gtc_prescaler

`default_nettype wire

// >>> logic/gtc_timer.sv
// Purpose: gated 16-bit timer/counter with prescaler and buffered wide access
// Assumes: all inputs synchronous to clk; software access by one-cycle strobes
// Notes:   unsynchronized counting samples the pin once per clk, so the
//          external clock must stay well below half the system clock
`timescale 1ns/1ns
`default_nettype none

module gtc_timer
  import gtc_pkg::*;
#(
  parameter int COUNT_W = GTC_COUNT_W,
  parameter int BYTE_W  = GTC_BYTE_W
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  // control bits
  input  wire logic                    timerOn,
  input  wire logic                    gateEnable,
  input  wire logic                    gatePolarity,
  input  wire logic                    wideAccessEnable,
  input  wire logic                    asyncSelect,
  input  wire logic [GTC_PS_SEL_W-1:0] prescaleSelect,
  input  wire logic [GTC_CS_W-1:0]     clockSelect,
  input  wire logic                    sleepMode,
  // external signals
  input  wire logic                    extClockPin,
  input  wire logic                    gateSignal,
  // software count access
  input  wire logic                    countLowWrite,
  input  wire logic                    countHighWrite,
  input  wire logic [BYTE_W-1:0]       countWrData,
  input  wire logic                    countLowRead,
  input  wire logic                    countHighRead,
  input  wire logic                    overflowClear,
  output logic      [BYTE_W-1:0]       countRdData_ff,
  output logic      [COUNT_W-1:0]      countPair_ff,
  output logic                         overflowFlag_ff
);

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  logic                       extSync1_ff;
  logic                       extSync2_ff;
  logic                       extRaw_ff;
  logic                       extPrev_ff;
  logic                       armed_ff;
  logic                       onPrev_ff;
  logic [GTC_INSTR_DIV_W-1:0] instrDiv_ff;
  logic [BYTE_W-1:0]          highBuf_ff;
  logic                       extSelected;
  logic                       extLevel;
  logic                       extRise;
  logic                       extFall;
  logic                       gateActive;
  logic                       countEnable;
  logic                       srcTick;
  logic                       psTick;
  logic                       countWrite;
  logic                       psClear;
  logic                       rollOver;
  logic [COUNT_W-1:0]         nxt_countPair;

  // -------------------------------------------------------------------------
  // external clock conditioning
  // -------------------------------------------------------------------------
  assign extSelected = (clockSelect == GTC_CS_EXT) || (clockSelect == GTC_CS_EXT_INV);

  // synchronizer is frozen while sleeping, so no synchronized edges appear
  always_ff @(posedge clk) begin
    if (srst) begin
      extSync1_ff <= 1'b0;
      extSync2_ff <= 1'b0;
    end else if (ce && !sleepMode) begin
      extSync1_ff <= extClockPin;
      extSync2_ff <= extSync1_ff;
    end
  end

  // unsynchronized path: one sample only, keeps running in sleep
  always_ff @(posedge clk) begin
    if (srst) begin
      extRaw_ff <= 1'b0;
    end else if (ce) begin
      extRaw_ff <= extClockPin;
    end
  end

  // a switch between paths can fake or hide one edge; tolerated by design
  assign extLevel = (asyncSelect ? extRaw_ff : extSync2_ff)
                    ^ (clockSelect == GTC_CS_EXT_INV);

  always_ff @(posedge clk) begin
    if (srst) begin
      extPrev_ff <= 1'b0;
    end else if (ce) begin
      extPrev_ff <= extLevel;
    end
  end

  assign extRise = extLevel && !extPrev_ff;
  assign extFall = !extLevel && extPrev_ff;

  // -------------------------------------------------------------------------
  // falling edge arming before the first counted rising edge
  // -------------------------------------------------------------------------
  assign countWrite = countLowWrite || countHighWrite;

  always_ff @(posedge clk) begin
    if (srst) begin
      onPrev_ff <= 1'b0;
    end else if (ce) begin
      onPrev_ff <= timerOn;
    end
  end

  // disarm on disable, on enable and on any count byte write
  always_ff @(posedge clk) begin
    if (srst) begin
      armed_ff <= 1'b0;
    end else if (ce) begin
      if (!timerOn || !onPrev_ff || countWrite) begin
        armed_ff <= 1'b0;
      end else if (extFall) begin
        armed_ff <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // enable, gate and source tick
  // -------------------------------------------------------------------------
  assign gateActive  = (gateSignal == gatePolarity);
  assign countEnable = timerOn && (!gateEnable || gateActive);

  // instruction clock divider, one tick every four system clocks
  always_ff @(posedge clk) begin
    if (srst) begin
      instrDiv_ff <= '0;
    end else if (ce) begin
      instrDiv_ff <= instrDiv_ff + GTC_INSTR_DIV_W'(1);
    end
  end

  // internal sources stop in sleep; only the external source with async select runs on
  always_comb begin
    srcTick = 1'b0;
    unique case (clockSelect)
      GTC_CS_INSTR:   srcTick = !sleepMode && (instrDiv_ff == GTC_INSTR_LAST);
      GTC_CS_SYS:     srcTick = !sleepMode;
      GTC_CS_EXT,
      GTC_CS_EXT_INV: srcTick = extRise && armed_ff
                                && (asyncSelect || !sleepMode);
    endcase
  end

  // wide mode: only a low byte write clears the prescaler
  assign psClear = countLowWrite || (countHighWrite && !wideAccessEnable);

  gtc_prescaler #(
    .SEL_W (GTC_PS_SEL_W),
    .CNT_W (GTC_PS_CNT_W)
  ) uPrescaler (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .clr     (psClear),
    .tick    (srcTick && countEnable),
    .sel     (prescaleSelect),
    .outTick (psTick)
  );

  // -------------------------------------------------------------------------
  // counter and software writes
  // -------------------------------------------------------------------------
  assign rollOver = psTick && !countWrite && (countPair_ff == {COUNT_W{1'b1}});

  // a count write wins over a coincident increment, except a wide mode high byte write, which only loads the buffer
  always_comb begin
    nxt_countPair = countPair_ff;
    if (countLowWrite && wideAccessEnable) begin
      nxt_countPair = {highBuf_ff, countWrData};
    end else if (countLowWrite) begin
      nxt_countPair = {countPair_ff[COUNT_W-1:BYTE_W], countWrData};
    end else if (countHighWrite && !wideAccessEnable) begin
      nxt_countPair = {countWrData, countPair_ff[BYTE_W-1:0]};
    end else if (psTick) begin
      nxt_countPair = countPair_ff + COUNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      countPair_ff <= GTC_COUNT_RST;
    end else if (ce) begin
      countPair_ff <= nxt_countPair;
    end
  end

  // -------------------------------------------------------------------------
  // high byte buffer and read data
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      highBuf_ff <= GTC_BYTE_RST;
    end else if (ce && wideAccessEnable) begin
      if (countHighWrite) begin
        highBuf_ff <= countWrData;
      end else if (countLowRead) begin
        highBuf_ff <= countPair_ff[COUNT_W-1:BYTE_W];
      end
    end
  end

  // reads come from the clk-domain count, so they are always coherent
  always_ff @(posedge clk) begin
    if (srst) begin
      countRdData_ff <= GTC_BYTE_RST;
    end else if (ce) begin
      if (countLowRead) begin
        countRdData_ff <= countPair_ff[BYTE_W-1:0];
      end else if (countHighRead) begin
        countRdData_ff <= wideAccessEnable ? highBuf_ff
                                           : countPair_ff[COUNT_W-1:BYTE_W];
      end
    end
  end

  // -------------------------------------------------------------------------
  // overflow flag, set wins over clear
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      overflowFlag_ff <= 1'b0;
    end else if (ce) begin
      if (rollOver) begin
        overflowFlag_ff <= 1'b1;
      end else if (overflowClear) begin
        overflowFlag_ff <= 1'b0;
      end
    end
  end

endmodule : gtc_timer

`default_nettype wire

// >>> pkg/gtc_pkg.sv
// Purpose: shared constants for the gated 16-bit timer/counter
// Assumes: single clock domain, clk at 100 MHz, synchronous active-high reset
// Notes:   clock select encoding and reset values are defined here only
//
// Summary of operation
// - 16-bit up counter; software writes load the count directly, except a wide mode high byte write.
// - counts only when on; gate enable picks gated or continuous counting.
// - undivided system clock source advances four counts per instruction cycle.
// - external counting needs a falling edge before the first counted rising edge.
// - external source increments on rising edges, synchronized or unsynchronized.
// - 2-bit prescale select divides by 1,2,4,8; count write clears prescaler, except a wide mode high byte write.
// - async select skips the synchronizer; external counting continues in sleep.
// - synchronizer is frozen during sleep, so only async counting proceeds.
// - mode switch between sync and async may drop or add one increment.
// - count byte reads stay valid while counting from the external clock.
// - wide mode: low byte read copies high byte into buffer; high reads buffer.
// - wide mode: high byte goes to buffer, low byte write loads both bytes.
// - wide mode: high byte write leaves prescaler alone; low byte write clears it.
// - gated mode counts only while the gate is active, otherwise holds.
// - gate polarity 1 counts on gate high, polarity 0 on gate low.
// - counter rolls from all ones to zero and sets the overflow flag; a coincident wide mode high byte write lets it roll but blocks the flag.

package gtc_pkg;

  localparam int          GTC_COUNT_W     = 16;
  localparam int          GTC_BYTE_W      = 8;
  localparam int          GTC_PS_SEL_W    = 2;
  localparam int          GTC_PS_CNT_W    = 3;
  localparam int          GTC_CS_W        = 2;
  localparam int          GTC_INSTR_DIV_W = 2;

  localparam logic [15:0] GTC_COUNT_RST   = 16'h0000;
  localparam logic [7:0]  GTC_BYTE_RST    = 8'h00;
  localparam logic [1:0]  GTC_INSTR_LAST  = 2'h3;   // four system clocks per instruction

  // clock source selections
  localparam logic [1:0]  GTC_CS_INSTR    = 2'h0;   // instruction clock, system clock / 4
  localparam logic [1:0]  GTC_CS_SYS      = 2'h1;   // undivided system clock
  localparam logic [1:0]  GTC_CS_EXT      = 2'h2;   // routed external clock pin
  localparam logic [1:0]  GTC_CS_EXT_INV  = 2'h3;   // routed external clock pin, inverted

endpackage : gtc_pkg

// >>> sim/gtc_ext_model.sv
// Purpose: far-side model of the external clock pin and gate input
// Assumes: tasks are called from the bench on falling clk edges
// Notes:   the clock pin rests low between bursts
`timescale 1ns/1ns
`default_nettype none
module gtc_ext_model (
  input  wire logic clk,
  output var logic  extClockPin,
  output var logic  gateSignal
);
  initial begin
    extClockPin = 1'h0;
    gateSignal  = 1'h0;
  end
  // each pin level stands three clk cycles, above the two-cycle minimum
  task automatic level(input logic v);
    @(negedge clk);
    extClockPin = v;
    repeat (2) @(negedge clk);
  endtask : level
  // n full periods, each opening with a falling edge; no comparator path
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'h0);
      level(1'h1);
    end
    level(1'h0);
  endtask : pulses
  task automatic gate(input logic v);
    @(negedge clk);
    gateSignal = v;
  endtask : gate
endmodule : gtc_ext_model
`default_nettype wire

// >>> sim/gtc_timer_monitor.sv
// Purpose: port-level checks for gtc_timer
// Assumes: one clk domain, srst synchronous active high
// Notes:   repeats let pipelined ticks settle before a hold is judged
`timescale 1ns/1ns
`default_nettype none
module gtc_timer_monitor
  import gtc_pkg::*;
#(
  parameter int COUNT_W = GTC_COUNT_W,
  parameter int BYTE_W  = GTC_BYTE_W
) (
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               ce,
  input wire logic               timerOn,
  input wire logic               gateEnable,
  input wire logic               gatePolarity,
  input wire logic               wideAccessEnable,
  input wire logic               asyncSelect,
  input wire logic [1:0]         prescaleSelect,
  input wire logic [1:0]         clockSelect,
  input wire logic               sleepMode,
  input wire logic               extClockPin,
  input wire logic               gateSignal,
  input wire logic               countLowWrite,
  input wire logic               countHighWrite,
  input wire logic [BYTE_W-1:0]  countWrData,
  input wire logic               countLowRead,
  input wire logic               countHighRead,
  input wire logic               overflowClear,
  input wire logic [BYTE_W-1:0]  countRdData_ff,
  input wire logic [COUNT_W-1:0] countPair_ff,
  input wire logic               overflowFlag_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // byte views of the count
  wire logic              anyWr = countLowWrite | countHighWrite;
  wire logic [BYTE_W-1:0] cntLo = countPair_ff[BYTE_W-1:0];
  wire logic [BYTE_W-1:0] cntHi = countPair_ff[COUNT_W-1:BYTE_W];
  lo_wr_a: assert property (countLowWrite && ce |=> cntLo == $past(countWrData))
    else $error("low byte write not loaded");
  off_hold_a: assert property ((!timerOn && ce && !anyWr)[*3] |=> $stable(countPair_ff))
    else $error("count moved while off");
  sys_cnt_a: assert property ((timerOn && !gateEnable && !sleepMode && ce && !anyWr
    && clockSelect == GTC_CS_SYS && prescaleSelect == 2'h0)[*3]
    |=> countPair_ff == $past(countPair_ff) + 16'h0001) else $error("clk source miss");
  gate_hold_a: assert property ((timerOn && gateEnable && gateSignal != gatePolarity
    && ce && !anyWr)[*4] |=> $stable(countPair_ff)) else $error("count moved, gate off");
  ovf_set_a: assert property ($past(countPair_ff) == 16'hFFFF && countPair_ff == 16'h0000
    && !$past(anyWr) && !$past(srst) |-> overflowFlag_ff) else $error("rollover no flag");
  ovf_clr_a: assert property ((!timerOn)[*4] ##0 (overflowClear && ce) |=> !overflowFlag_ff)
    else $error("flag not cleared");
  ovf_keep_a: assert property (overflowFlag_ff && !overflowClear |=> overflowFlag_ff)
    else $error("flag dropped");
  rd_lo_a: assert property (countLowRead && ce |=> countRdData_ff == $past(cntLo))
    else $error("low read wrong");
  rd_wide_a: assert property (wideAccessEnable && countLowRead && !countHighWrite && ce
    ##1 (!countLowRead && !countHighWrite) ##1 (countHighRead && !countLowRead
    && !countHighWrite && wideAccessEnable && ce) |=> countRdData_ff == $past(cntHi, 3))
    else $error("high read not snapshot");
endmodule : gtc_timer_monitor
bind gtc_timer gtc_timer_monitor #(.COUNT_W(COUNT_W), .BYTE_W(BYTE_W)) mon (.*);
`default_nettype wire

// >>> sim/tb.sv
// Purpose: self-checking bench for gtc_timer
// Assumes: inputs change on falling clk edges; ce tied high
// Notes:   timer is stopped around every count write
`timescale 1ns/1ns
`default_nettype none
module tb
  import gtc_pkg::*;
;
  logic        clk = 1'h0, srst, ce, timerOn, gateEnable, gatePolarity, sleepMode;
  logic        wideAccessEnable, asyncSelect, countLowWrite, countHighWrite, overflowClear;
  logic        countLowRead, countHighRead, extClockPin, gateSignal, overflowFlag_ff;
  logic [1:0]  prescaleSelect, clockSelect;
  logic [7:0]  countWrData, countRdData_ff, rdv;
  logic [15:0] countPair_ff;
  int          n_mismatch = 0, n_checks = 0;
  always #5 clk = ~clk;
  gtc_timer dut (.*);
  gtc_ext_model ext (.clk(clk), .extClockPin(extClockPin), .gateSignal(gateSignal));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic hi, input logic [7:0] d);
    @(negedge clk);
    countHighWrite = hi;
    countLowWrite = !hi;
    countWrData = d;
    @(negedge clk);
    countHighWrite = 1'h0;
    countLowWrite = 1'h0;
  endtask : wr
  task automatic rd(input logic hi);
    @(negedge clk);
    countHighRead = hi;
    countLowRead = !hi;
    @(negedge clk);
    countHighRead = 1'h0;
    countLowRead = 1'h0;
    rdv = countRdData_ff;
  endtask : rd
  // on for n edges exactly, then let pipelined ticks land
  task automatic run(input int n);
    @(negedge clk);
    timerOn = 1'h1;
    repeat (n) @(negedge clk);
    timerOn = 1'h0;
    repeat (6) @(negedge clk);
  endtask : run
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // tests
  // ----------------------------------------
  task automatic t_ovf;
    clockSelect = GTC_CS_SYS;
    wr(1'h1, 8'hFF);
    wr(1'h0, 8'hFE);
    chk("pair", 16'hFFFE, countPair_ff);
    rd(1'h0);
    chk("rdLo", 16'h00FE, {8'h00, rdv});
    run(3);
    chk("wrap", 16'h0001, countPair_ff);
    chk("flag", 16'h0001, {15'h0000, overflowFlag_ff});
    rd(1'h1);
    chk("rdHi", 16'h0000, {8'h00, rdv});
    @(negedge clk);
    overflowClear = 1'h1;
    @(negedge clk);
    overflowClear = 1'h0;
    chk("clr", 16'h0000, {15'h0000, overflowFlag_ff});
    $display("test overflow done");
  endtask : t_ovf
  task automatic t_ps;
    for (int i = 0; i < 5; i++) begin
      prescaleSelect = (i == 4) ? 2'h0 : 2'(i);
      clockSelect = (i == 4) ? GTC_CS_INSTR : GTC_CS_SYS;
      wr(1'h1, 8'h00);
      wr(1'h0, 8'h00);
      run(16);
      chk("div", (i == 4) ? 16'h0004 : 16'h0010 >> i, countPair_ff);
    end
    $display("test prescale done");
  endtask : t_ps
  task automatic t_ext;
    prescaleSelect = 2'h0;
    // last pass runs the inverted pin select, awake and synchronized
    for (int i = 0; i < 5; i++) begin
      clockSelect = (i == 4) ? GTC_CS_EXT_INV : GTC_CS_EXT;
      asyncSelect = i[0];
      sleepMode = i[1];
      wr(1'h1, 8'h00);
      wr(1'h0, 8'h00);
      timerOn = 1'h1;
      ext.level(1'h1);
      // one more edge so an unarmed synchronized rise would have landed
      @(negedge clk);
      chk("arm", 16'h0000, countPair_ff);
      ext.pulses(4);
      repeat (4) @(negedge clk);
      timerOn = 1'h0;
      chk("ext", (i == 2) ? 16'h0000 : (i == 4) ? 16'h0005 : 16'h0004,
          countPair_ff);
    end
    {sleepMode, asyncSelect} = 2'h0;
    $display("test external done");
  endtask : t_ext
  task automatic t_gate;
    clockSelect = GTC_CS_SYS;
    gateEnable = 1'h1;
    for (int i = 0; i < 4; i++) begin
      gatePolarity = i[0];
      ext.gate(i[1]);
      wr(1'h0, 8'h00);
      run(8);
      chk("gate", (i[0] == i[1]) ? 16'h0008 : 16'h0000, countPair_ff);
    end
    gateEnable = 1'h0;
    $display("test gate done");
  endtask : t_gate
  task automatic t_wide;
    wideAccessEnable = 1'h1;
    wr(1'h1, 8'h12);
    chk("buf", 16'h0008, countPair_ff);
    wr(1'h0, 8'hFE);
    chk("load", 16'h12FE, countPair_ff);
    @(negedge clk);
    timerOn = 1'h1;
    rd(1'h0);
    rd(1'h1);
    timerOn = 1'h0;
    chk("snap", 16'h0012, {8'h00, rdv});
    prescaleSelect = 2'h1;
    wr(1'h0, 8'h00);
    run(1);
    wr(1'h1, 8'h00);
    run(1);
    // low write loaded the buffered high byte, so the high half stays 8'h12
    chk("psKeep", 16'h1201, countPair_ff);
    wideAccessEnable = 1'h0;
    $display("test wide done");
  endtask : t_wide
  initial begin
    {srst, ce, timerOn, gateEnable, gatePolarity, sleepMode} = 6'h30;
    {wideAccessEnable, asyncSelect, countLowWrite, countHighWrite} = 4'h0;
    {overflowClear, countLowRead, countHighRead} = 3'h0;
    {prescaleSelect, clockSelect, countWrData} = 12'h000;
    repeat (12) @(negedge clk);
    srst = 1'h0;
    t_ovf();
    t_ps();
    t_ext();
    t_gate();
    t_wide();
    close_out();
  end
  // watchdog, far beyond the roughly five hundred cycles the tests take
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule : tb
`default_nettype wire
